// ### common/smagg_pkg.sv
// Shared constants and types for the status mask aggregator.
package smagg_pkg;

	localparam int unsigned SMAGG_W = 16;
	localparam int unsigned SMAGG_GROUPS = 4;

	localparam logic [15:0] SMAGG_FID_HW_MASK = 16'h0010;
	localparam logic [15:0] SMAGG_FID_COM_MASK = 16'h0011;
	localparam logic [15:0] SMAGG_FID_SW_MASK = 16'h0012;
	localparam logic [15:0] SMAGG_FID_SENS_MASK = 16'h0013;
	localparam logic [15:0] SMAGG_FID_SENS_FLAGS = 16'h0014;

	localparam logic [15:0] SMAGG_MASK_RST = 16'h0000;
	localparam logic [15:0] SMAGG_HW_VALID = 16'h000f;
	localparam logic [15:0] SMAGG_COM_VALID = 16'h0001;
	localparam logic [15:0] SMAGG_SW_VALID = 16'h000f;
	localparam logic [15:0] SMAGG_SENS_VALID = 16'h0001;

	localparam logic [1:0] SMAGG_GRP_HW = 2'h0;
	localparam logic [1:0] SMAGG_GRP_COM = 2'h1;
	localparam logic [1:0] SMAGG_GRP_SW = 2'h2;
	localparam logic [1:0] SMAGG_GRP_SENS = 2'h3;

	typedef enum logic [2:0] {
		SMAGG_SEL_HW = 3'b000,
		SMAGG_SEL_COM = 3'b001,
		SMAGG_SEL_SW = 3'b010,
		SMAGG_SEL_SENS = 3'b011,
		SMAGG_SEL_FLAGS = 3'b100,
		SMAGG_SEL_NONE = 3'b111
	} smagg_sel_t;

	typedef struct packed {
		logic [11:0] reserved;
		logic nonvolatile_write_unlocked;
		logic no_differential_correction;
		logic internal_receiver_unlocked;
		logic pulse_per_second_unlocked;
	} smagg_hw_flags_t;

	typedef struct packed {
		logic [14:0] reserved;
		logic no_external_receiver_data;
	} smagg_com_flags_t;

	typedef struct packed {
		logic [14:0] reserved;
		logic excess_input_indicator;
	} smagg_sens_flags_t;

	typedef struct packed {
		logic master_alert_flag;
		logic sensor_summary;
		logic software_summary;
		logic communication_summary;
		logic hardware_summary;
	} smagg_summary_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] field_id;
		logic [15:0] wdata;
	} smagg_cmd_t;

	typedef struct packed {
		logic valid;
		logic ok;
		logic [15:0] rdata;
	} smagg_rsp_t;

	typedef struct packed {
		logic [3:0][15:0] mask;
		smagg_summary_t summary;
		smagg_rsp_t rsp;
	} smagg_state_t;

endpackage : smagg_pkg

// ### test/smagg_host.sv
// Host model that issues field read and write commands.
`timescale 1ns/1ps
module smagg_host import smagg_pkg::*; (
	input wire logic ref_clk,
	output smagg_cmd_t cmd,
	input smagg_rsp_t rsp
);
	initial begin
		cmd = '0;
	end
	task automatic xfer(input logic wr, input logic [15:0] id, input logic [15:0] wd,
		output smagg_rsp_t r);
		@(posedge ref_clk);
		cmd <= '{valid: 1'b1, write: wr, field_id: id, wdata: wd};
		@(posedge ref_clk);
		cmd <= '{valid: 1'b0, write: ~wr, field_id: ~id, wdata: ~wd};
		#1;
		r = rsp;
	endtask : xfer
	// Write then read back to back.
	task automatic wr_rd(input logic [15:0] id, input logic [15:0] wd,
		output smagg_rsp_t r0, output smagg_rsp_t r1);
		@(posedge ref_clk);
		cmd <= '{valid: 1'b1, write: 1'b1, field_id: id, wdata: wd};
		@(posedge ref_clk);
		cmd <= '{valid: 1'b1, write: 1'b0, field_id: id, wdata: ~wd};
		#1;
		r0 = rsp;
		@(posedge ref_clk);
		cmd <= '{valid: 1'b0, write: 1'b1, field_id: ~id, wdata: wd};
		#1;
		r1 = rsp;
	endtask : wr_rd
endmodule : smagg_host

// ### test/status_mask_aggregator_bench.sv
// Self-checking bench for the status mask aggregator.
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module status_mask_aggregator_bench import smagg_pkg::*;;
	localparam logic [3:0][15:0] valid_bits = {SMAGG_SENS_VALID, SMAGG_SW_VALID,
		SMAGG_COM_VALID, SMAGG_HW_VALID};
	logic ref_clk;
	logic rstn;
	smagg_cmd_t cmd;
	smagg_rsp_t rsp;
	smagg_summary_t sum_w;
	logic [3:0][15:0] flg;
	logic [3:0][15:0] msk;
	int failures;
	int samples_checked;
	int cycles;

	smagg_top u_dut (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.cmd(cmd),
		.rsp(rsp),
		.hardware_condition_flags(smagg_hw_flags_t'(flg[0])),
		.communication_condition_flags(smagg_com_flags_t'(flg[1])),
		.software_condition_flags(flg[2]),
		.sensor_condition_flags(smagg_sens_flags_t'(flg[3])),
		.self_test_summary_word(sum_w)
	);
	smagg_host u_host (.ref_clk(ref_clk), .cmd(cmd), .rsp(rsp));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic summarize();
		$display("checks=%0d failures=%0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : summarize

	initial begin
		cycles = 0;
		forever begin
			@(posedge ref_clk);
			cycles++;
			if (cycles == 3000) begin
				failures++;
				summarize();
			end
		end
	end

	task automatic access(input logic wr, input logic [15:0] id, input logic [15:0] wd,
		input logic ok, input logic [15:0] exp);
		smagg_rsp_t r;
		u_host.xfer(wr, id, wd, r);
		`CHK({r.valid, r.ok, r.rdata}, {1'b1, ok, exp})
	endtask : access

	task automatic wr_mask(input int g, input logic [15:0] v);
		access(1'b1, 16'(SMAGG_FID_HW_MASK + g), v, 1'b1, v);
		msk[g] = v;
	endtask : wr_mask

	// Writes a mask and reads it on the very next edge.
	task automatic wr_rd_chk(input int g, input logic [15:0] v);
		smagg_rsp_t r0;
		smagg_rsp_t r1;
		u_host.wr_rd(16'(SMAGG_FID_HW_MASK + g), v, r0, r1);
		`CHK({r0.valid, r0.ok, r0.rdata}, {1'b1, 1'b1, v})
		`CHK({r1.valid, r1.ok, r1.rdata}, {1'b1, 1'b1, v})
		msk[g] = v;
	endtask : wr_rd_chk

	// Applies a flag vector and compares the summary word with the masked OR.
	task automatic flags_chk(input logic [3:0][15:0] f);
		logic [4:0] e;
		e = '0;
		for (int g = 0; g < 4; g++) begin
			e[g] = |(f[g] & msk[g] & valid_bits[g]);
		end
		e[4] = |e[3:0];
		@(posedge ref_clk);
		flg <= f;
		@(posedge ref_clk);
		#1;
		`CHK(sum_w, e)
	endtask : flags_chk

	initial begin
		logic [3:0][15:0] f;
		logic [15:0] mset [2];
		logic [15:0] id;
		rstn = 1'b0;
		flg = '0;
		msk = '0;
		failures = 0;
		samples_checked = 0;
		mset[0] = 16'hffff;
		mset[1] = 16'haaaa;
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		#1;
		`CHK(sum_w, 5'h00)
		for (int g = 0; g < 4; g++) begin
			id = 16'(SMAGG_FID_HW_MASK + g);
			access(1'b0, id, 16'h0000, 1'b1, SMAGG_MASK_RST);
			wr_mask(g, 16'(16'ha5c3 ^ g));
			access(1'b0, id, 16'h0000, 1'b1, 16'(16'ha5c3 ^ g));
		end
		access(1'b1, SMAGG_FID_SENS_FLAGS, 16'hffff, 1'b0, 16'h0000);
		access(1'b0, 16'h0015, 16'h0000, 1'b0, 16'h0000);
		access(1'b1, 16'h000f, 16'h1234, 1'b0, 16'h0000);
		for (int g = 0; g < 4; g++) begin
			wr_rd_chk(g, 16'(16'h5a3c ^ g));
		end
		f = '0;
		f[3] = 16'h8001;
		flags_chk(f);
		access(1'b0, SMAGG_FID_SENS_FLAGS, 16'h0000, 1'b1, 16'h8001);
		for (int s = 0; s < 2; s++) begin
			for (int g = 0; g < 4; g++) begin
				wr_mask(g, mset[s]);
			end
			for (int g = 0; g < 4; g++) begin
				for (int b = 0; b < 16; b++) begin
					f = '0;
					f[g][b] = 1'b1;
					flags_chk(f);
				end
			end
			flags_chk({4{16'hffff}});
		end
		flags_chk('0);
		flags_chk({4{16'hffff}});
		@(posedge ref_clk);
		rstn <= 1'b0;
		msk = '0;
		#1;
		`CHK(sum_w, 5'h00)
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		flags_chk({4{16'hffff}});
		access(1'b0, SMAGG_FID_SW_MASK, 16'h0000, 1'b1, SMAGG_MASK_RST);
		summarize();
	end
endmodule : status_mask_aggregator_bench

// ### verilog/smagg_field_decode.sv
// Field identifier decoder for the status mask aggregator.
`timescale 1ns/1ps
module smagg_field_decode import smagg_pkg::*; (
	input wire logic [15:0] field_id,
	output smagg_sel_t sel
);

	function automatic smagg_sel_t smagg_decode(input logic [15:0] id);
		smagg_sel_t s;
		s = SMAGG_SEL_NONE;
		// [RULE_04] Hardware, communication ids.
		if (id == SMAGG_FID_HW_MASK) begin
			s = SMAGG_SEL_HW;
		end else if (id == SMAGG_FID_COM_MASK) begin
			s = SMAGG_SEL_COM;
		// [RULE_05] Software, sensor ids.
		end else if (id == SMAGG_FID_SW_MASK) begin
			s = SMAGG_SEL_SW;
		end else if (id == SMAGG_FID_SENS_MASK) begin
			s = SMAGG_SEL_SENS;
		end else if (id == SMAGG_FID_SENS_FLAGS) begin
			s = SMAGG_SEL_FLAGS;
		end
		return s;
	endfunction : smagg_decode

	// Maps each field identifier onto a mask slot, the sensor flag field or none.
	assign sel = smagg_decode(field_id);

endmodule : smagg_field_decode

// ### verilog/smagg_group_reduce.sv
// Masked OR reduction of one group of condition flags.
`timescale 1ns/1ps
module smagg_group_reduce import smagg_pkg::*; (
	input wire logic [15:0] flags,
	input wire logic [15:0] mask,
	input wire logic [15:0] valid_bits,
	output logic hit
);

	// Reserved positions are dropped before the reduction.
	assign hit = |(flags & mask & valid_bits);

endmodule : smagg_group_reduce

// ### verilog/smagg_top.sv
// Status mask aggregator: field commands, enable masks and summary word.
//
// Behaviour
// [RULE_01] Sensor summary is OR of sensor flags ANDed with sensor mask.
// [RULE_02] Sensor flags: excess input at bit 0, bits 1 to 15 reserved.
// [RULE_03] Masks are written and read only through field read and write commands.
// [RULE_04] Hardware mask is field 0x0010, communication mask 0x0011, any value.
// [RULE_05] Software mask is field 0x0012, sensor mask 0x0013, any value.
// [RULE_06] Enabled hardware flag raises hardware summary and master alert.
// [RULE_07] Enabled communication flag raises communication summary and master alert.
// [RULE_08] Enabled software flag raises software summary and master alert; the code counts only software flag bits 0 to 3.
// [RULE_09] Enabled sensor flag raises sensor summary and master alert.
// [RULE_10] Hardware flags occupy bits 0 to 3, bits 4 to 15 reserved.
// [RULE_11] Communication flags: no external receiver data at bit 0, rest reserved.
// [RULE_12] Master alert is OR of four summaries; reserved mask bits do nothing.
`timescale 1ns/1ps
module smagg_top import smagg_pkg::*; (
	input wire logic ref_clk,
	input wire logic rstn,
	input smagg_cmd_t cmd,
	output smagg_rsp_t rsp,
	input smagg_hw_flags_t hardware_condition_flags,
	input smagg_com_flags_t communication_condition_flags,
	input wire logic [15:0] software_condition_flags,
	input smagg_sens_flags_t sensor_condition_flags,
	output smagg_summary_t self_test_summary_word
);

	smagg_state_t st_q;
	smagg_state_t st_d;
	smagg_sel_t sel;
	logic [3:0][15:0] grp_flags;
	logic [3:0][15:0] grp_valid;
	logic [3:0] grp_hit;
	logic [1:0] grp_idx;
	logic is_mask;

	smagg_field_decode u_decode (
		.field_id(cmd.field_id),
		.sel(sel)
	);

	// [RULE_10] Hardware flag layout.
	assign grp_flags[SMAGG_GRP_HW] = hardware_condition_flags;
	// [RULE_11] Communication flag layout.
	assign grp_flags[SMAGG_GRP_COM] = communication_condition_flags;
	assign grp_flags[SMAGG_GRP_SW] = software_condition_flags;
	// [RULE_02] Sensor flag layout.
	assign grp_flags[SMAGG_GRP_SENS] = sensor_condition_flags;

	// [RULE_12] Reserved positions masked.
	assign grp_valid[SMAGG_GRP_HW] = SMAGG_HW_VALID;
	assign grp_valid[SMAGG_GRP_COM] = SMAGG_COM_VALID;
	assign grp_valid[SMAGG_GRP_SW] = SMAGG_SW_VALID;
	assign grp_valid[SMAGG_GRP_SENS] = SMAGG_SENS_VALID;

	for (genvar g = 0; g < SMAGG_GROUPS; g++) begin : g_grp
		smagg_group_reduce u_reduce (
			.flags(grp_flags[g]),
			.mask(st_q.mask[g]),
			.valid_bits(grp_valid[g]),
			.hit(grp_hit[g])
		);
	end

	assign grp_idx = sel[1:0];
	assign is_mask = (sel == SMAGG_SEL_HW) || (sel == SMAGG_SEL_COM)
		|| (sel == SMAGG_SEL_SW) || (sel == SMAGG_SEL_SENS);

	always_comb begin
		st_d = st_q;
		st_d.rsp = '0;
		// [RULE_01] Sensor group summary.
		st_d.summary.sensor_summary = grp_hit[SMAGG_GRP_SENS];
		// [RULE_06] Hardware group summary.
		st_d.summary.hardware_summary = grp_hit[SMAGG_GRP_HW];
		// [RULE_07] Communication group summary.
		st_d.summary.communication_summary = grp_hit[SMAGG_GRP_COM];
		// [RULE_08] Software group summary.
		st_d.summary.software_summary = grp_hit[SMAGG_GRP_SW];
		// [RULE_09] Master alert from all groups.
		st_d.summary.master_alert_flag = |grp_hit;
		if (cmd.valid) begin
			st_d.rsp.valid = 1'b1;
			// [RULE_03] Field command access.
			unique case (sel)
				SMAGG_SEL_HW, SMAGG_SEL_COM, SMAGG_SEL_SW, SMAGG_SEL_SENS: begin
					st_d.rsp.ok = 1'b1;
					// [RULE_04] Whole word stored.
					if (cmd.write) begin
						st_d.mask[grp_idx] = cmd.wdata;
						st_d.rsp.rdata = cmd.wdata;
					end else begin
						st_d.rsp.rdata = st_q.mask[grp_idx];
					end
				end
				SMAGG_SEL_FLAGS: begin
					st_d.rsp.ok = !cmd.write;
					st_d.rsp.rdata = cmd.write ? 16'h0000 : sensor_condition_flags;
				end
				SMAGG_SEL_NONE: begin
					st_d.rsp.ok = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_q.mask <= {SMAGG_GROUPS{SMAGG_MASK_RST}};
			st_q.summary <= '0;
			st_q.rsp <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rsp = st_q.rsp;
	assign self_test_summary_word = st_q.summary;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	// Reference hits for the checks below, one bit per group.
	logic [3:0] chk_hit;
	assign chk_hit[SMAGG_GRP_HW] = |(hardware_condition_flags
		& st_q.mask[SMAGG_GRP_HW] & SMAGG_HW_VALID);
	assign chk_hit[SMAGG_GRP_COM] = |(communication_condition_flags
		& st_q.mask[SMAGG_GRP_COM] & SMAGG_COM_VALID);
	assign chk_hit[SMAGG_GRP_SW] = |(software_condition_flags
		& st_q.mask[SMAGG_GRP_SW] & SMAGG_SW_VALID);
	assign chk_hit[SMAGG_GRP_SENS] = sensor_condition_flags.excess_input_indicator
		&& st_q.mask[SMAGG_GRP_SENS][0];

	sequence s_hw_hit;
		|(hardware_condition_flags & st_q.mask[SMAGG_GRP_HW] & SMAGG_HW_VALID);
	endsequence

	sequence s_com_hit;
		|(communication_condition_flags & st_q.mask[SMAGG_GRP_COM] & SMAGG_COM_VALID);
	endsequence

	sequence s_sw_hit;
		|(software_condition_flags & st_q.mask[SMAGG_GRP_SW] & SMAGG_SW_VALID);
	endsequence

	sequence s_sens_hit;
		sensor_condition_flags.excess_input_indicator
			&& st_q.mask[SMAGG_GRP_SENS][0];
	endsequence

	sequence s_mask_write;
		cmd.valid && cmd.write && is_mask;
	endsequence

	sequence s_same_read;
		cmd.valid && !cmd.write && (cmd.field_id == $past(cmd.field_id));
	endsequence

	sequence s_flags_read;
		cmd.valid && !cmd.write && (sel == SMAGG_SEL_FLAGS);
	endsequence

	sequence s_flags_write;
		cmd.valid && cmd.write && (sel == SMAGG_SEL_FLAGS);
	endsequence

	a_sensor_summary: assert property ( // [RULE_01]
		##1 self_test_summary_word.sensor_summary
			== |($past(sensor_condition_flags) & $past(st_q.mask[SMAGG_GRP_SENS])
			& SMAGG_SENS_VALID)
	) else $error("sensor summary does not follow masked flags");

	a_sensor_reserved: assert property ( // [RULE_02]
		(sensor_condition_flags.excess_input_indicator == 1'b0)
			|=> !self_test_summary_word.sensor_summary
	) else $error("reserved sensor bits raised the sensor summary");

	a_hw_master: assert property ( // [RULE_06]
		s_hw_hit |=> self_test_summary_word.hardware_summary
			&& self_test_summary_word.master_alert_flag
	) else $error("hardware hit did not raise summary and master");

	a_com_master: assert property ( // [RULE_07]
		s_com_hit |=> self_test_summary_word.communication_summary
			&& self_test_summary_word.master_alert_flag
	) else $error("communication hit did not raise summary and master");

	a_sw_master: assert property ( // [RULE_08]
		s_sw_hit |=> self_test_summary_word.software_summary
			&& self_test_summary_word.master_alert_flag
	) else $error("software hit did not raise summary and master");

	a_sens_master: assert property ( // [RULE_09]
		s_sens_hit |=> self_test_summary_word.sensor_summary
			&& self_test_summary_word.master_alert_flag
	) else $error("sensor hit did not raise summary and master");

	a_hw_reserved: assert property ( // [RULE_10]
		(hardware_condition_flags[3:0] == 4'h0) |=> !self_test_summary_word.hardware_summary
	) else $error("reserved hardware bits raised the hardware summary");

	a_com_reserved: assert property ( // [RULE_11]
		!communication_condition_flags.no_external_receiver_data
			|=> !self_test_summary_word.communication_summary
	) else $error("reserved communication bits raised the summary");

	a_master_quiet: assert property ( // [RULE_12]
		(chk_hit == 4'h0)
			|=> !self_test_summary_word.master_alert_flag
	) else $error("master alert raised with no enabled flag");

	a_write_echo: assert property ( // [RULE_03]
		s_mask_write |=> rsp.valid && rsp.ok && (rsp.rdata == $past(cmd.wdata))
	) else $error("mask write not acknowledged with its value");

	a_write_readback: assert property ( // [RULE_03]
		s_mask_write ##1 s_same_read |=> rsp.ok && (rsp.rdata == $past(cmd.wdata, 2))
	) else $error("mask read did not return the last written value");

	a_hw_com_ids: assert property ( // [RULE_04]
		cmd.valid && ((cmd.field_id == SMAGG_FID_HW_MASK)
			|| (cmd.field_id == SMAGG_FID_COM_MASK)) |=> rsp.valid && rsp.ok
	) else $error("hardware or communication mask field refused");

	a_sw_sens_ids: assert property ( // [RULE_05]
		cmd.valid && ((cmd.field_id == SMAGG_FID_SW_MASK)
			|| (cmd.field_id == SMAGG_FID_SENS_MASK)) |=> rsp.valid && rsp.ok
	) else $error("software or sensor mask field refused");

	a_unknown_field: assert property ( // [RULE_03]
		cmd.valid && (sel == SMAGG_SEL_NONE) |=> rsp.valid && !rsp.ok
	) else $error("unknown field identifier was accepted");

	a_no_cmd_idle: assert property ( // [RULE_03]
		!cmd.valid |=> !rsp.valid
	) else $error("answer without a command");

	a_mask_hold: assert property ( // [RULE_03]
		!cmd.valid [*2] |-> $stable(st_q.mask)
	) else $error("mask changed without a field write");

	a_flags_read: assert property ( // [RULE_02]
		s_flags_read |=> rsp.valid && rsp.ok
			&& (rsp.rdata == $past(sensor_condition_flags))
	) else $error("sensor flag read returned a wrong word");

	a_flags_refused: assert property ( // [RULE_03]
		s_flags_write |=> rsp.valid && !rsp.ok
			&& (rsp.rdata == 16'h0000)
	) else $error("write to the sensor flag field was accepted");

	a_flags_no_store: assert property ( // [RULE_03]
		s_flags_write |=> $stable(st_q.mask)
	) else $error("write to the sensor flag field changed a mask");

	a_refused_zero: assert property ( // [RULE_03]
		cmd.valid && (sel == SMAGG_SEL_NONE) |=> (rsp.rdata == 16'h0000)
	) else $error("refused field returned nonzero data");

	a_cmd_answer: assert property ( // [RULE_03]
		cmd.valid |=> rsp.valid
	) else $error("command taken without an answer");

	a_hw_store: assert property ( // [RULE_04]
		cmd.valid && cmd.write && (cmd.field_id == SMAGG_FID_HW_MASK)
			|=> (st_q.mask[SMAGG_GRP_HW] == $past(cmd.wdata))
	) else $error("hardware mask write not stored");

	a_com_store: assert property ( // [RULE_04]
		cmd.valid && cmd.write && (cmd.field_id == SMAGG_FID_COM_MASK)
			|=> (st_q.mask[SMAGG_GRP_COM] == $past(cmd.wdata))
	) else $error("communication mask write not stored");

	a_sw_store: assert property ( // [RULE_05]
		cmd.valid && cmd.write && (cmd.field_id == SMAGG_FID_SW_MASK)
			|=> (st_q.mask[SMAGG_GRP_SW] == $past(cmd.wdata))
	) else $error("software mask write not stored");

	a_sens_store: assert property ( // [RULE_05]
		cmd.valid && cmd.write && (cmd.field_id == SMAGG_FID_SENS_MASK)
			|=> (st_q.mask[SMAGG_GRP_SENS] == $past(cmd.wdata))
	) else $error("sensor mask write not stored");

	a_master_or: assert property ( // [RULE_12]
		self_test_summary_word.master_alert_flag
			== (self_test_summary_word.hardware_summary
			|| self_test_summary_word.communication_summary
			|| self_test_summary_word.software_summary
			|| self_test_summary_word.sensor_summary)
	) else $error("master alert differs from the OR of the summaries");

	a_hw_quiet: assert property ( // [RULE_12]
		!chk_hit[SMAGG_GRP_HW] |=> !self_test_summary_word.hardware_summary
	) else $error("hardware summary raised with no enabled flag");

	a_com_quiet: assert property ( // [RULE_12]
		!chk_hit[SMAGG_GRP_COM] |=> !self_test_summary_word.communication_summary
	) else $error("communication summary raised with no enabled flag");

	a_sw_quiet: assert property ( // [RULE_12]
		!chk_hit[SMAGG_GRP_SW] |=> !self_test_summary_word.software_summary
	) else $error("software summary raised with no enabled flag");

	a_sens_quiet: assert property ( // [RULE_12]
		!chk_hit[SMAGG_GRP_SENS] |=> !self_test_summary_word.sensor_summary
	) else $error("sensor summary raised with no enabled flag");

endmodule : smagg_top
